//--- hib_power_defs.vh
`ifndef HIB_POWER_DEFS_VH
`define HIB_POWER_DEFS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_HZ              20000000
`define CLK_CYC_PER_US      (`CLK_HZ / 1000000)
`define T_RAMP_20MS_US      20000
`define T_RAMP_5MS_US       5000
`define T_RAMP_100MS_US     100000
`define T_RAMP_2US_US       2
`define RAMP_CNT_W          21
// 20 MHz / 610 is close to the 32.768 kHz oscillator rate
`define TOY_DIV_CYC         610
`define TOY_DIV_W           10

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W              12
`define OFS_SCRATCH_A       12'h018
`define OFS_SCRATCH_B       12'h01C
`define OFS_WAKE_MASK       12'h034
`define OFS_POWER_CTRL      12'h03C
`define OFS_TOY_COUNT       12'h040
`define OFS_TOY_COMPARE     12'h044
`define OFS_OSC_CTRL        12'h048
`define OFS_STATUS          12'h04C
`define OFS_WAKE_CAUSE      12'h05C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_MATCH_ENABLE    9
`define RAMP_SEL_LSB        2
`define RAMP_SEL_MSB        3
`define BIT_MATCH_FLAG      25
`define BIT_RETURN_FLAG     2
`define BIT_FIRST_FLAG      0
`define BIT_OSC_ENABLE      0
`define STAT_STATE_LSB      0
`define STAT_STATE_MSB      3
`define BIT_STAT_WAKE_DRIVE 4
`define BIT_STAT_WAKE_PIN   5
`define BIT_STAT_FW_CAPT    6
`define BIT_STAT_RAMP_BUSY  7

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define RAMP_CODE_20MS      2'h0
`define RAMP_CODE_5MS       2'h1
`define RAMP_CODE_100MS     2'h2
`define RAMP_CODE_2US       2'h3
`define RST_RAMP_SEL        2'h0
`define RST_WORD            32'h00000000

`endif

//--- down_timer.v
`timescale 1ns/1ps
`default_nettype none

// loadable down counter; expire pulses one cycle after the last count
module down_timer #(
    parameter W = 21
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         load,
    input  wire [W-1:0] value,
    output reg          busy,
    output reg          expire
);

    reg [W-1:0] count_q;

    always @(posedge clk) begin
        if (!nrst) begin
            count_q <= {W{1'b0}};
            busy    <= 1'b0;
            expire  <= 1'b0;
        end else if (load) begin
            count_q <= value;
            busy    <= 1'b1;
            expire  <= 1'b0;
        end else if (busy) begin
            count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
            // value 0 is treated as 1 so the timer can never wrap
            if (count_q <= {{(W-1){1'b0}}, 1'b1}) begin
                busy   <= 1'b0;
                expire <= 1'b1;
            end else begin
                expire <= 1'b0;
            end
        end else begin
            expire <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- hibernate_power_control.v
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hib_power_defs.vh"

module hibernate_power_control #(
    parameter RAMP_20MS_CYC  = `T_RAMP_20MS_US * `CLK_CYC_PER_US,
    parameter RAMP_5MS_CYC   = `T_RAMP_5MS_US * `CLK_CYC_PER_US,
    parameter RAMP_100MS_CYC = `T_RAMP_100MS_US * `CLK_CYC_PER_US,
    parameter RAMP_2US_CYC   = `T_RAMP_2US_US * `CLK_CYC_PER_US,
    parameter TOY_DIV        = `TOY_DIV_CYC
) (
    input  wire                CLK,
    input  wire                NRST,
    input  wire                PSEL,
    input  wire                PENABLE,
    input  wire                PWRITE,
    input  wire [`ADDR_W-1:0]  PADDR,
    input  wire [31:0]         PWDATA,
    output wire [31:0]         PRDATA,
    output wire                PREADY,
    output wire                PSLVERR,
    input  wire                SUPPLY_GOOD,
    input  wire                TOY_FIREWALL_N,
    input  wire                WAKE_IN,
    output wire                WAKE_OUT,
    output wire                WAKE_OE_N,
    output wire                OSC_ENABLE,
    output wire                CORE_RESET_N
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [3:0] ST_OFF   = 4'h1;
    localparam [3:0] ST_RUN   = 4'h2;
    localparam [3:0] ST_HIBER = 4'h4;
    localparam [3:0] ST_RAMP  = 4'h8;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [3:0]              state_q;
    reg  [3:0]              state_d;
    reg                     sg_prev_q;
    reg                     fw_capt_q;
    reg                     rise_seen_q;
    reg                     first_flag_q;
    reg                     return_flag_q;
    reg                     match_flag_q;
    reg                     match_en_q;
    reg  [1:0]              ramp_sel_q;
    reg                     osc_en_q;
    reg                     wake_drive_q;
    reg                     core_rst_n_q;
    reg  [31:0]             scratch_a_q;
    reg  [31:0]             scratch_b_q;
    reg  [31:0]             toy_q;
    reg  [31:0]             toy_cmp_q;
    reg  [31:0]             prdata_q;
    reg  [31:0]             rd_mux;
    reg                     rd_hit;
    reg  [`RAMP_CNT_W-1:0]  ramp_value;
    wire                    sg_rise;
    wire                    sg_fall;
    wire                    apb_wr;
    wire                    apb_setup;
    wire                    cause_wr;
    wire                    ramp_busy;
    wire                    ramp_expire;
    wire                    div_busy;
    wire                    div_expire;
    wire                    toy_tick;
    wire                    toy_match;
    wire                    hib_wakeup;

    // ----------------------------------------------------------------
    // supply-good edges and firewall capture
    // ----------------------------------------------------------------
    assign sg_rise = SUPPLY_GOOD & ~sg_prev_q;
    assign sg_fall = ~SUPPLY_GOOD & sg_prev_q;

    always @(posedge CLK) begin
        if (!NRST) begin
            sg_prev_q   <= 1'b0;
            fw_capt_q   <= 1'b0;
            rise_seen_q <= 1'b0;
        end else begin
            sg_prev_q   <= SUPPLY_GOOD;
            rise_seen_q <= sg_rise;
            if (sg_rise) begin
                fw_capt_q <= ~TOY_FIREWALL_N;
            end
        end
    end

    // classification one cycle after the rise uses only the captured level,
    // so a firewall released early in the ramp cannot change the outcome
    // tied firewall counts
    assign hib_wakeup = rise_seen_q & fw_capt_q;

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (rise_seen_q) begin
                    state_d = ST_RAMP;
                end
            end
            ST_RUN: begin
                if (sg_fall) begin
                    state_d = TOY_FIREWALL_N ? ST_OFF : ST_HIBER;
                end
            end
            ST_HIBER: begin
                if (rise_seen_q) begin
                    state_d = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (sg_fall) begin
                    state_d = TOY_FIREWALL_N ? ST_OFF : ST_HIBER;
                end else if (ramp_expire) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (!NRST) begin
            state_q      <= ST_OFF;
            core_rst_n_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            core_rst_n_q <= (state_d == ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // core supply ramp timer
    // ----------------------------------------------------------------
    // the rise cycle loads the timer before ramp_sel_q has taken the forced
    // code, so the selector is forced to 20ms here as well
    always @* begin
        case (rise_seen_q ? `RAMP_CODE_20MS : ramp_sel_q)
            `RAMP_CODE_20MS:  ramp_value = RAMP_20MS_CYC[`RAMP_CNT_W-1:0];
            `RAMP_CODE_5MS:   ramp_value = RAMP_5MS_CYC[`RAMP_CNT_W-1:0];
            `RAMP_CODE_100MS: ramp_value = RAMP_100MS_CYC[`RAMP_CNT_W-1:0];
            `RAMP_CODE_2US:   ramp_value = RAMP_2US_CYC[`RAMP_CNT_W-1:0];
            default:          ramp_value = RAMP_20MS_CYC[`RAMP_CNT_W-1:0];
        endcase
    end

    down_timer #(
        .W      (`RAMP_CNT_W)
    ) u_ramp (
        .clk    (CLK),
        .nrst   (NRST),
        .load   (rise_seen_q),
        .value  (ramp_value),
        .busy   (ramp_busy),
        .expire (ramp_expire)
    );

    // ----------------------------------------------------------------
    // always-on counter, ticked at the oscillator rate
    // ----------------------------------------------------------------
    down_timer #(
        .W      (`TOY_DIV_W)
    ) u_div (
        .clk    (CLK),
        .nrst   (NRST),
        .load   (~div_busy),
        .value  (TOY_DIV[`TOY_DIV_W-1:0] - {{(`TOY_DIV_W-1){1'b0}}, 1'b1}),
        .busy   (div_busy),
        .expire (div_expire)
    );

    assign toy_tick  = div_expire & osc_en_q;
    assign toy_match = (toy_q == toy_cmp_q);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr    = PSEL & PENABLE & PWRITE;
    assign cause_wr  = apb_wr & (PADDR == `OFS_WAKE_CAUSE);
    assign PREADY    = PSEL & PENABLE;
    assign PSLVERR   = PSEL & PENABLE & ~rd_hit;
    assign PRDATA    = prdata_q;

    always @* begin
        rd_mux = `RST_WORD;
        rd_hit = 1'b1;
        case (PADDR)
            `OFS_SCRATCH_A:   rd_mux = scratch_a_q;
            `OFS_SCRATCH_B:   rd_mux = scratch_b_q;
            `OFS_WAKE_MASK:   rd_mux[`BIT_MATCH_ENABLE] = match_en_q;
            `OFS_POWER_CTRL:  rd_mux[`RAMP_SEL_MSB:`RAMP_SEL_LSB] = ramp_sel_q;
            `OFS_TOY_COUNT:   rd_mux = toy_q;
            `OFS_TOY_COMPARE: rd_mux = toy_cmp_q;
            `OFS_OSC_CTRL:    rd_mux[`BIT_OSC_ENABLE] = osc_en_q;
            `OFS_STATUS: begin
                rd_mux[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_q;
                rd_mux[`BIT_STAT_WAKE_DRIVE]            = wake_drive_q;
                rd_mux[`BIT_STAT_WAKE_PIN]              = WAKE_IN;
                rd_mux[`BIT_STAT_FW_CAPT]               = fw_capt_q;
                rd_mux[`BIT_STAT_RAMP_BUSY]             = ramp_busy;
            end
            `OFS_WAKE_CAUSE: begin
                rd_mux[`BIT_MATCH_FLAG]  = match_flag_q;
                rd_mux[`BIT_RETURN_FLAG] = return_flag_q;
                rd_mux[`BIT_FIRST_FLAG]  = first_flag_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // read data is taken in the setup cycle so it leaves a flip-flop
    always @(posedge CLK) begin
        if (!NRST) begin
            prdata_q <= `RST_WORD;
        end else if (apb_setup && !PWRITE) begin
            prdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            scratch_a_q <= `RST_WORD;
            scratch_b_q <= `RST_WORD;
            match_en_q  <= 1'b0;
            toy_cmp_q   <= `RST_WORD;
        end else if (apb_wr) begin
            if (PADDR == `OFS_SCRATCH_A) begin
                scratch_a_q <= PWDATA;
            end
            if (PADDR == `OFS_SCRATCH_B) begin
                scratch_b_q <= PWDATA;
            end
            if (PADDR == `OFS_WAKE_MASK) begin
                match_en_q <= PWDATA[`BIT_MATCH_ENABLE];
            end
            if (PADDR == `OFS_TOY_COMPARE) begin
                toy_cmp_q <= PWDATA;
            end
        end
    end

    // ramp select: the supply rise overrides any write in the same cycle
    always @(posedge CLK) begin
        if (!NRST) begin
            ramp_sel_q <= `RST_RAMP_SEL;
        end else if (rise_seen_q) begin
            ramp_sel_q <= `RAMP_CODE_20MS;
        end else if (apb_wr && PADDR == `OFS_POWER_CTRL) begin
            ramp_sel_q <= PWDATA[`RAMP_SEL_MSB:`RAMP_SEL_LSB];
        end
    end

    // ----------------------------------------------------------------
    // oscillator enable and counter
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            osc_en_q <= 1'b0;
        end else if (rise_seen_q) begin
            if (!fw_capt_q) begin
                osc_en_q <= 1'b0;
            end
        end else if (apb_wr && PADDR == `OFS_OSC_CTRL) begin
            osc_en_q <= PWDATA[`BIT_OSC_ENABLE];
        end
    end

    // the counter has no reset path from supply-good at all
    always @(posedge CLK) begin
        if (!NRST) begin
            toy_q <= `RST_WORD;
        end else if (apb_wr && PADDR == `OFS_TOY_COUNT) begin
            toy_q <= PWDATA;
        end else if (toy_tick) begin
            toy_q <= toy_q + 32'h00000001;
        end
    end

    // ----------------------------------------------------------------
    // wake output
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            wake_drive_q <= 1'b0;
        end else if (toy_tick && toy_match && match_en_q) begin
            wake_drive_q <= 1'b1;
        end else if (cause_wr && !hib_wakeup) begin
            wake_drive_q <= 1'b0;
        end
    end

    assign WAKE_OUT     = 1'b0;
    assign WAKE_OE_N    = ~wake_drive_q;
    assign OSC_ENABLE   = osc_en_q;
    assign CORE_RESET_N = core_rst_n_q;

    // ----------------------------------------------------------------
    // wakeup cause flags: a rise wins over a clearing write
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            first_flag_q  <= 1'b0;
            return_flag_q <= 1'b0;
            match_flag_q  <= 1'b0;
        end else if (rise_seen_q) begin
            first_flag_q  <= 1'b1;
            return_flag_q <= fw_capt_q;
            match_flag_q  <= wake_drive_q & fw_capt_q;
        end else if (cause_wr) begin
            first_flag_q  <= 1'b0;
            return_flag_q <= 1'b0;
            match_flag_q  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- hibernate_power_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_power_defs.vh"

module hibernate_power_control_sva #(
    parameter RAMP_20MS_CYC = 50
) (
    input wire logic               CLK,
    input wire logic               NRST,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [`ADDR_W-1:0] PADDR,
    input wire logic               PREADY,
    input wire logic               PSLVERR,
    input wire logic               SUPPLY_GOOD,
    input wire logic               TOY_FIREWALL_N,
    input wire logic               WAKE_OUT,
    input wire logic               WAKE_OE_N,
    input wire logic               OSC_ENABLE,
    input wire logic               CORE_RESET_N
);
    localparam int RMAX = RAMP_20MS_CYC + 4;
    logic [`RAMP_CNT_W-1:0] ramp_q;
    wire logic              clr_w;

    assign clr_w = PSEL && PENABLE && PWRITE && PADDR == `OFS_WAKE_CAUSE;

    // ------------------------------------------------
    // cycles spent with supply good but core held
    // ------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!NRST || !SUPPLY_GOOD || CORE_RESET_N)
            ramp_q <= '0;
        else
            ramp_q <= ramp_q + 1'b1;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    wake_pull_low_a: assert property (WAKE_OUT == 1'b0)
        else $error("wake line driven high");
    bus_ready_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase without ready");
    bus_error_a: assert property (PSEL && PENABLE && PADDR == 12'h038 |-> PSLVERR)
        else $error("unmapped access not flagged");
    reset_state_a: assert property (disable iff (1'b0) !NRST |=> WAKE_OE_N && !OSC_ENABLE)
        else $error("outputs not cleared by reset");
    rise_hold_a: assert property ($rose(SUPPLY_GOOD) |-> !CORE_RESET_N [*8])
        else $error("core released right after supply rise");
    ramp_done_a: assert property ($rose(CORE_RESET_N) |-> ramp_q >= RAMP_20MS_CYC && ramp_q <= RMAX)
        else $error("core released outside the ramp window");
    ramp_bound_a: assert property (ramp_q <= RMAX)
        else $error("ramp wait overran");
    osc_kept_a: assert property ($rose(SUPPLY_GOOD) && !TOY_FIREWALL_N |=> ##1 $stable(OSC_ENABLE))
        else $error("oscillator enable changed on wakeup");
    osc_off_a: assert property ($rose(SUPPLY_GOOD) && TOY_FIREWALL_N |-> ##2 !OSC_ENABLE)
        else $error("oscillator left on at power-on");
    wake_hold_a: assert property (!WAKE_OE_N && !clr_w |=> !WAKE_OE_N)
        else $error("wake drive dropped without clear");
    wake_cause_a: assert property ($fell(WAKE_OE_N) |-> $past(OSC_ENABLE))
        else $error("wake drive without running counter");
    supply_drop_a: assert property (!SUPPLY_GOOD |=> !CORE_RESET_N)
        else $error("core running without supply good");
endmodule

bind hibernate_power_control hibernate_power_control_sva #(.RAMP_20MS_CYC(RAMP_20MS_CYC)) sva_u (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .SUPPLY_GOOD(SUPPLY_GOOD),
    .TOY_FIREWALL_N(TOY_FIREWALL_N), .WAKE_OUT(WAKE_OUT), .WAKE_OE_N(WAKE_OE_N),
    .OSC_ENABLE(OSC_ENABLE), .CORE_RESET_N(CORE_RESET_N)
);

`default_nettype wire

//--- board_power_model.sv
`timescale 1ns/1ps
`default_nettype none

module board_power_model #(
    parameter LEAD = 10,
    parameter GAP  = 20,
    parameter REL  = 20
) (
    input  wire logic clk,
    input  wire logic wake_out,
    input  wire logic wake_oe_n,
    output logic      supply_good,
    output logic      toy_firewall_n,
    output wire logic wake_in
);
    assign wake_in = wake_oe_n ? 1'b1 : wake_out;

    initial begin
        supply_good = 1'b0;
        toy_firewall_n = 1'b1;
    end

    task automatic power_up(input logic fw_n);
        @(posedge clk);
        toy_firewall_n <= fw_n;
        repeat (GAP) @(posedge clk);
        supply_good <= 1'b1;
        if (!fw_n) begin
            repeat (REL) @(posedge clk);
            toy_firewall_n <= 1'b1;
        end
    endtask

    task automatic hibernate(input int wait_max, output logic woke);
        int n;
        @(posedge clk);
        toy_firewall_n <= 1'b0;
        repeat (LEAD) @(posedge clk);
        supply_good <= 1'b0;
        n = 0;
        while (wake_in && n < wait_max) begin
            @(posedge clk);
            n++;
        end
        woke = !wake_in || wait_max == 0;
        power_up(1'b0);
    endtask

    task automatic power_down();
        @(posedge clk);
        supply_good <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- test_hibernate_power_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_power_defs.vh"

module test_hibernate_power_control;
    localparam RAMP = 50;
    localparam logic [31:0] FIRST = 32'h00000001 << `BIT_FIRST_FLAG;
    localparam logic [31:0] RET   = 32'h00000001 << `BIT_RETURN_FLAG;
    localparam logic [31:0] MATCH = 32'h00000001 << `BIT_MATCH_FLAG;

    logic               clk, nrst, psel, penable, pwrite, woke, err;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0]        pwdata, rd;
    wire logic [31:0]   prdata;
    wire logic          pready, pslverr, supply_good, toy_firewall_n, wake_in;
    wire logic          wake_out, wake_oe_n, osc_enable, core_reset_n;
    int                 miscompares = 0;
    int                 num_checks = 0;
    logic [11:0]        regs [4] = '{`OFS_WAKE_CAUSE, `OFS_POWER_CTRL, `OFS_WAKE_MASK,
                                     `OFS_OSC_CTRL};

    hibernate_power_control #(.RAMP_20MS_CYC(RAMP), .TOY_DIV(4)) dut_u (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SUPPLY_GOOD(supply_good), .TOY_FIREWALL_N(toy_firewall_n),
        .WAKE_IN(wake_in), .WAKE_OUT(wake_out), .WAKE_OE_N(wake_oe_n),
        .OSC_ENABLE(osc_enable), .CORE_RESET_N(core_reset_n)
    );

    board_power_model board_u (
        .clk(clk), .wake_out(wake_out), .wake_oe_n(wake_oe_n), .supply_good(supply_good),
        .toy_firewall_n(toy_firewall_n), .wake_in(wake_in)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer: setup, then access held until ready is sampled
    task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // wake selects the wake drive, otherwise core release
    task automatic wait_on(input bit wake);
        int n;
        n = 0;
        while ((wake ? wake_oe_n !== 1'b0 : core_reset_n !== 1'b1) && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) begin
            miscompares++;
            summarize();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        chk({wake_out, wake_oe_n, osc_enable, core_reset_n}, 32'h00000004);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], '0);
            chk(rd, '0);
        end
        apb(1'b0, 12'h038, '0);
        chk({31'h00000000, err}, 32'h00000001);
        chk(rd, '0);
        apb(1'b1, `OFS_SCRATCH_A, 32'hA5C30F1E);
        apb(1'b0, `OFS_SCRATCH_A, '0);
        chk(rd, 32'hA5C30F1E);
        $display("test registers done");

        board_u.power_up(1'b1);
        wait_on(1'b0);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, FIRST);
        chk(osc_enable, 1'b0);
        apb(1'b1, `OFS_WAKE_CAUSE, 32'h00000001);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, '0);
        $display("test first power-up done");

        // alarm armed, then hibernate; a short ramp code must be overridden
        apb(1'b1, `OFS_OSC_CTRL, 32'h00000001);
        apb(1'b1, `OFS_TOY_COUNT, '0);
        apb(1'b1, `OFS_TOY_COMPARE, 32'h00000005);
        apb(1'b1, `OFS_WAKE_MASK, 32'h00000001 << `BIT_MATCH_ENABLE);
        apb(1'b1, `OFS_POWER_CTRL, 32'h0000000C);
        board_u.hibernate(600, woke);
        chk(woke, 1'b1);
        wait_on(1'b0);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, MATCH | RET | FIRST);
        chk({wake_oe_n, wake_in}, 32'h00000000);
        chk(osc_enable, 1'b1);
        apb(1'b0, `OFS_POWER_CTRL, '0);
        chk(rd[3:2], `RAMP_CODE_20MS);
        apb(1'b0, `OFS_STATUS, '0);
        chk(rd, 32'h00000052);
        apb(1'b0, `OFS_TOY_COUNT, '0);
        chk(rd >= 32'h00000005, 1'b1);
        apb(1'b1, `OFS_WAKE_MASK, '0);
        apb(1'b1, `OFS_WAKE_CAUSE, '0);
        @(posedge clk);
        chk({wake_oe_n, wake_in}, 32'h00000003);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, '0);
        $display("test alarm wakeup done");

        // second entry lands while the core supply is still ramping
        board_u.hibernate(0, woke);
        board_u.hibernate(0, woke);
        wait_on(1'b0);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, RET | FIRST);
        chk(osc_enable, 1'b1);
        $display("test entry during ramp done");

        board_u.power_down();
        board_u.power_up(1'b1);
        wait_on(1'b0);
        apb(1'b0, `OFS_WAKE_CAUSE, '0);
        chk(rd, FIRST);
        chk(osc_enable, 1'b0);
        $display("test cold cycle done");
        summarize();
    end
endmodule

`default_nettype wire
